// ==== design/srtc_defs.vh ====
`ifndef SRTC_DEFS_VH
`define SRTC_DEFS_VH

// register indices; byte address is four times the index
`define SRTC_IDX_SEC     4'h0
`define SRTC_IDX_MIN     4'h1
`define SRTC_IDX_HOUR    4'h2
`define SRTC_IDX_WDAY    4'h3
`define SRTC_IDX_DAY     4'h4
`define SRTC_IDX_MON     4'h5
`define SRTC_IDX_YEAR    4'h6
`define SRTC_IDX_ADJ     4'h7
`define SRTC_IDX_AW_MIN  4'h8
`define SRTC_IDX_AW_HOUR 4'h9
`define SRTC_IDX_AW_DAYS 4'hA
`define SRTC_IDX_AD_MIN  4'hB
`define SRTC_IDX_AD_HOUR 4'hC
`define SRTC_IDX_CTRL1   4'hE
`define SRTC_IDX_CTRL2   4'hF

// control 1 fields
`define SRTC_C1_WALE 7
`define SRTC_C1_DALE 6
`define SRTC_C1_H24  5
`define SRTC_C1_SCR  4
`define SRTC_C1_TEST 3
// control 2 fields
`define SRTC_C2_VDSL 7
`define SRTC_C2_VDET 6
`define SRTC_C2_XST  5
`define SRTC_C2_PON  4
`define SRTC_C2_SCR  3
`define SRTC_C2_CTFG 2
`define SRTC_C2_WAFG 1
`define SRTC_C2_DAFG 0
// correction register resolution bit
`define SRTC_ADJ_DEV 7
// month register century bit
`define SRTC_MON_CENT 7

// periodic interrupt select codes
`define SRTC_CT_2HZ   3'h2
`define SRTC_CT_1HZ   3'h3
`define SRTC_CT_SEC   3'h4
`define SRTC_CT_MIN   3'h5
`define SRTC_CT_HOUR  3'h6
`define SRTC_CT_MONTH 3'h7

// timing counts, in 50 ns clock cycles: half second, detector delay, correction step
`define SRTC_HALF_SEC_CYC  26'h989680
`define SRTC_DET_DELAY_CYC 22'h1E8480
`define SRTC_ADJ_STEP_CYC  26'h4B0
// seconds between correction points
`define SRTC_ADJ_SECS_COARSE 6'h14
`define SRTC_ADJ_SECS_FINE   6'h3C

// serial command layout
`define SRTC_CMD_READ 3

`endif

// ==== design/srtc_core.v ====
// Notes on behaviour
// (RULE_01) serial data is accepted or returned only while chip select is high
// (RULE_02) host keeps the serial clock at or below 1 MHz
// (RULE_03) serial transfers are ignored while the main supply is low
// (RULE_04) seconds to two-digit year counters, all readable and writable
// (RULE_05) year divisible by four is leap, February then has 29 days
// (RULE_06) weekly alarm matches hour, minute and any set of weekdays
// (RULE_07) daily alarm matches hour and minute every day
// (RULE_08) both alarms drive the one active-low interrupt pin
// (RULE_09) each alarm has a pollable match flag
// (RULE_10) rate correction: 3ppm steps to 189ppm, or 1ppm steps to 63ppm
// (RULE_11) supply detect output low while main supply is at or below threshold
// (RULE_12) supply detect output released high only after a fixed delay
// (RULE_13) sticky flag records any oscillator stop
// (RULE_14) cold start of backup supply resets control and sets power-on flag
// (RULE_15) backup supply sampled once a second, low result latched
// (RULE_16) periodic interrupt at 2 Hz, 1 Hz, minute, hour or monthly
// (RULE_17) pulse waveform for 1 and 2 Hz, held level for the others
// (RULE_18) periodic interrupt state is pollable as well as on the pin
// (RULE_19) crystal clock is always output, no disable
// (RULE_20) power-on clears correction and both control registers except halt flag
// (RULE_21) resolution bit clear selects coarse steps, set selects fine steps
// (RULE_22) serial data pin driven only in the read-data phase
// (RULE_23) serial state machine held in reset while chip select is low
`timescale 1ns/1ps
`include "srtc_defs.vh"

module srtc_core #(
	parameter [25:0] HALF_SEC_CYCLES  = `SRTC_HALF_SEC_CYC,
	parameter [21:0] DET_DELAY_CYCLES = `SRTC_DET_DELAY_CYC
) (
	input  wire        clock_in,
	input  wire        rst_n_in,
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [7:0]  paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output reg         pready_out,
	output reg         pslverr_out,
	input  wire        chip_select_in,
	input  wire        serial_clock_in,
	input  wire        serial_data_in,
	output reg         serial_data_out,
	output reg         serial_data_oe_out,
	input  wire        crystal_osc_in,
	input  wire        main_supply_low_in,
	input  wire        backup_cold_start_in,
	input  wire        osc_stopped_in,
	input  wire        backup_below_in,
	output reg         interrupt_out_n,
	output reg         main_supply_detect_n_out,
	output reg         crystal_clock_out,
	output reg         backup_threshold_sel_out
);

	localparam [2:0]  ST_CMD = 3'b001;
	localparam [2:0]  ST_WR  = 3'b010;
	localparam [2:0]  ST_RD  = 3'b100;
	localparam [25:0] ADJ_STEP = `SRTC_ADJ_STEP_CYC;
	localparam [25:0] HALF_M1  = HALF_SEC_CYCLES - 26'h1;

	// counters and registers
	reg [6:0]  sec;
	reg [6:0]  min;
	reg [5:0]  hour;
	reg [2:0]  wday;
	reg [5:0]  day;
	reg [7:0]  mon;
	reg [7:0]  year;
	reg [7:0]  adj;
	reg [6:0]  aw_min;
	reg [5:0]  aw_hour;
	reg [6:0]  aw_days;
	reg [6:0]  ad_min;
	reg [5:0]  ad_hour;
	reg [7:0]  ctrl1;
	reg [7:0]  ctrl2;
	// synchronisers: ce, sclk, sdi, xtal, main low, cold, osc stop, backup low
	reg [7:0]  sync1;
	reg [7:0]  sync2;
	reg        sclk_d;
	reg        cold_d;
	// time base
	reg [25:0] half_cnt;
	reg [25:0] half_lim;
	reg        half_phase;
	reg [5:0]  adj_secs;
	reg        adj_due;
	reg        min_evt_d;
	reg [21:0] det_cnt;
	// serial engine
	reg [2:0]  ser_state;
	reg [2:0]  ser_bit;
	reg [7:0]  ser_sh;
	reg [3:0]  ser_addr;
	reg        ser_wr;
	reg [7:0]  ser_wdat;
	// shared write port
	reg        wr_en;
	reg [3:0]  wr_idx;
	reg [7:0]  wr_dat;
	reg        ct_pin;

	wire       ce_s      = sync2[7];
	wire       sclk_s    = sync2[6];
	wire       sdi_s     = sync2[5];
	wire       vlow_s    = sync2[3];
	wire       cold_s    = sync2[2];
	wire       ostop_s   = sync2[1];
	wire       bklow_s   = sync2[0];
	wire       sclk_rise = sclk_s & ~sclk_d;
	wire       apb_acc   = psel_in & penable_in & ~pready_out;
	wire       apb_ok    = (paddr_in[1:0] == 2'h0) && (paddr_in[7:6] == 2'h0);
	wire [3:0] apb_idx   = paddr_in[5:2];
	wire       half_tick = (half_cnt >= half_lim);
	wire       sec_tick  = half_tick & half_phase;
	wire       min_evt   = sec_tick & (sec == 7'h59);
	wire       hour_evt  = min_evt & (min == 7'h59);
	wire       day_evt   = hour_evt & (hour == 6'h23);
	wire       mon_evt   = day_evt & (day == last_day(mon[4:0], year));
	wire [2:0] ct_sel    = ctrl1[2:0];
	wire       ct_level  = ct_sel[2];
	wire [25:0] adj_ext  = {{19{adj[6]}}, adj[6:0]};
	wire [25:0] adj_cyc  = adj_ext * ADJ_STEP;
	// bcd successors, cut to each counter's width where used
	wire [7:0] sec_inc   = bcd_inc({1'b0, sec});
	wire [7:0] min_inc   = bcd_inc({1'b0, min});
	wire [7:0] hour_inc  = bcd_inc({2'b00, hour});
	wire [7:0] day_inc   = bcd_inc({2'b00, day});
	wire [7:0] mon_inc   = bcd_inc({3'b000, mon[4:0]});
	// read bytes for the command's index and for the next index
	wire [7:0] rd_first  = reg_rd(ser_sh[6:3]);
	wire [7:0] rd_next   = reg_rd(ser_addr + 4'h1);

	// bcd increment of a two-digit value
	function [7:0] bcd_inc;
		input [7:0] v;
		begin
			if (v[3:0] == 4'h9) begin
				bcd_inc = {v[7:4] + 4'h1, 4'h0};
			end else begin
				bcd_inc = {v[7:4], v[3:0] + 4'h1};
			end
		end
	endfunction

	// last day of a month, bcd
	function [5:0] last_day;
		input [4:0] m;
		input [7:0] y;
		reg         leap;
		begin
			// (RULE_05) leap year check
			leap = (~y[4] & ((y[3:0] == 4'h0) | (y[3:0] == 4'h4) | (y[3:0] == 4'h8))) |
				(y[4] & ((y[3:0] == 4'h2) | (y[3:0] == 4'h6)));
			case (m)
				5'h02: last_day = leap ? 6'h29 : 6'h28;
				5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
				default: last_day = 6'h31;
			endcase
		end
	endfunction

	// register read mux, unused bits read zero
	function [7:0] reg_rd;
		input [3:0] i;
		begin
			if (i == `SRTC_IDX_SEC) reg_rd = {1'b0, sec};
			else if (i == `SRTC_IDX_MIN) reg_rd = {1'b0, min};
			else if (i == `SRTC_IDX_HOUR) reg_rd = {2'b00, hour};
			else if (i == `SRTC_IDX_WDAY) reg_rd = {5'h00, wday};
			else if (i == `SRTC_IDX_DAY) reg_rd = {2'b00, day};
			else if (i == `SRTC_IDX_MON) reg_rd = mon;
			else if (i == `SRTC_IDX_YEAR) reg_rd = year;
			else if (i == `SRTC_IDX_ADJ) reg_rd = adj;
			else if (i == `SRTC_IDX_AW_MIN) reg_rd = {1'b0, aw_min};
			else if (i == `SRTC_IDX_AW_HOUR) reg_rd = {2'b00, aw_hour};
			else if (i == `SRTC_IDX_AW_DAYS) reg_rd = {1'b0, aw_days};
			else if (i == `SRTC_IDX_AD_MIN) reg_rd = {1'b0, ad_min};
			else if (i == `SRTC_IDX_AD_HOUR) reg_rd = {2'b00, ad_hour};
			else if (i == `SRTC_IDX_CTRL1) reg_rd = ctrl1;
			else if (i == `SRTC_IDX_CTRL2) reg_rd = ctrl2;
			else reg_rd = 8'h00;
		end
	endfunction

	// half-second period, stretched or shortened at correction points
	always @* begin
		// (RULE_10) correction added once per interval
		half_lim = HALF_M1 + (adj_due ? adj_cyc : 26'h0);
	end

	// write port: serial write first, bus write otherwise
	always @* begin
		wr_en  = ser_wr | (apb_acc & pwrite_in & apb_ok);
		wr_idx = ser_wr ? ser_addr : apb_idx;
		wr_dat = ser_wr ? ser_wdat : pwdata_in[7:0];
	end

	// periodic pin level for the pulse and level modes
	always @* begin
		// (RULE_17) pulse in 1 and 2 Hz modes, held flag in level modes, low for codes 0 and 1
		if (ct_sel == `SRTC_CT_2HZ) ct_pin = (half_cnt < {1'b0, HALF_M1[25:1]});
		else if (ct_sel == `SRTC_CT_1HZ) ct_pin = ~half_phase;
		else if (ct_level) ct_pin = ctrl2[`SRTC_C2_CTFG];
		else ct_pin = 1'b0;
	end

	// input synchronisers and edge history
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			sync1  <= 8'h00;
			sync2  <= 8'h00;
			sclk_d <= 1'b0;
			cold_d <= 1'b0;
		end else begin
			sync1  <= {chip_select_in, serial_clock_in, serial_data_in, crystal_osc_in,
				main_supply_low_in, backup_cold_start_in, osc_stopped_in, backup_below_in};
			sync2  <= sync1;
			sclk_d <= sclk_s;
			cold_d <= cold_s;
		end
	end

	// time base and correction interval
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			half_cnt   <= 26'h0;
			half_phase <= 1'b0;
			adj_secs   <= 6'h0;
			adj_due    <= 1'b0;
			min_evt_d  <= 1'b0;
		end else begin
			min_evt_d <= min_evt;
			if (half_tick) begin
				half_cnt   <= 26'h0;
				half_phase <= ~half_phase;
				adj_due    <= 1'b0;
			end else begin
				half_cnt <= half_cnt + 26'h1;
			end
			// at or past the limit, so a fine to coarse switch never waits for a wrap
			// (RULE_21) resolution bit picks the interval
			if (sec_tick) begin
				if (adj_secs >= (adj[`SRTC_ADJ_DEV] ? `SRTC_ADJ_SECS_FINE : `SRTC_ADJ_SECS_COARSE) - 6'h1) begin
					adj_secs <= 6'h0;
					adj_due  <= (adj[6:0] != 7'h00);
				end else begin
					adj_secs <= adj_secs + 6'h1;
				end
			end
		end
	end

	// counters, registers and flags
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			sec     <= 7'h00;
			min     <= 7'h00;
			hour    <= 6'h00;
			wday    <= 3'h0;
			day     <= 6'h01;
			mon     <= 8'h01;
			year    <= 8'h00;
			adj     <= 8'h00;
			aw_min  <= 7'h00;
			aw_hour <= 6'h00;
			aw_days <= 7'h00;
			ad_min  <= 7'h00;
			ad_hour <= 6'h00;
			ctrl1   <= 8'h00;
			ctrl2   <= 8'h30;
		end else begin
			// (RULE_04) calendar carry chain
			if (sec_tick) sec <= (sec == 7'h59) ? 7'h00 : sec_inc[6:0];
			if (min_evt) min <= (min == 7'h59) ? 7'h00 : min_inc[6:0];
			if (hour_evt) hour <= (hour == 6'h23) ? 6'h00 : hour_inc[5:0];
			if (day_evt) begin
				wday <= (wday == 3'h6) ? 3'h0 : wday + 3'h1;
				day  <= mon_evt ? 6'h01 : day_inc[5:0];
			end
			if (mon_evt) begin
				mon[4:0] <= (mon[4:0] == 5'h12) ? 5'h01 : mon_inc[4:0];
				if (mon[4:0] == 5'h12) begin
					year <= (year == 8'h99) ? 8'h00 : bcd_inc(year);
					if (year == 8'h99) mon[`SRTC_MON_CENT] <= ~mon[`SRTC_MON_CENT];
				end
			end
			// host writes override the count
			if (wr_en) begin
				if (wr_idx == `SRTC_IDX_SEC) sec <= wr_dat[6:0];
				else if (wr_idx == `SRTC_IDX_MIN) min <= wr_dat[6:0];
				else if (wr_idx == `SRTC_IDX_HOUR) hour <= wr_dat[5:0];
				else if (wr_idx == `SRTC_IDX_WDAY) wday <= wr_dat[2:0];
				else if (wr_idx == `SRTC_IDX_DAY) day <= wr_dat[5:0];
				else if (wr_idx == `SRTC_IDX_MON) mon <= {wr_dat[7], 2'b00, wr_dat[4:0]};
				else if (wr_idx == `SRTC_IDX_YEAR) year <= wr_dat;
				else if (wr_idx == `SRTC_IDX_ADJ) adj <= wr_dat;
				else if (wr_idx == `SRTC_IDX_AW_MIN) aw_min <= wr_dat[6:0];
				else if (wr_idx == `SRTC_IDX_AW_HOUR) aw_hour <= wr_dat[5:0];
				else if (wr_idx == `SRTC_IDX_AW_DAYS) aw_days <= wr_dat[6:0];
				else if (wr_idx == `SRTC_IDX_AD_MIN) ad_min <= wr_dat[6:0];
				else if (wr_idx == `SRTC_IDX_AD_HOUR) ad_hour <= wr_dat[5:0];
				else if (wr_idx == `SRTC_IDX_CTRL1) ctrl1 <= wr_dat;
				else if (wr_idx == `SRTC_IDX_CTRL2) begin
					ctrl2[`SRTC_C2_VDSL] <= wr_dat[`SRTC_C2_VDSL];
					ctrl2[`SRTC_C2_SCR]  <= wr_dat[`SRTC_C2_SCR];
					// writes can only clear flags, by writing zero, never set them
					ctrl2[6:4] <= ctrl2[6:4] & wr_dat[6:4];
					ctrl2[2:0] <= ctrl2[2:0] & wr_dat[2:0];
				end
			end
			// (RULE_09) pollable alarm flags
			// (RULE_06) weekly alarm match
			if (min_evt_d && ctrl1[`SRTC_C1_WALE] && (min == aw_min) && (hour == aw_hour) && aw_days[wday])
				ctrl2[`SRTC_C2_WAFG] <= 1'b1;
			// (RULE_07) daily alarm match
			if (min_evt_d && ctrl1[`SRTC_C1_DALE] && (min == ad_min) && (hour == ad_hour))
				ctrl2[`SRTC_C2_DAFG] <= 1'b1;
			// (RULE_16) periodic events set the level flag
			if (ct_level && (((ct_sel == `SRTC_CT_SEC) && sec_tick) || ((ct_sel == `SRTC_CT_MIN) && min_evt) ||
				((ct_sel == `SRTC_CT_HOUR) && hour_evt) || ((ct_sel == `SRTC_CT_MONTH) && mon_evt)))
				ctrl2[`SRTC_C2_CTFG] <= 1'b1;
			// (RULE_18) pulse modes mirror the pin into the flag
			if (!ct_level) ctrl2[`SRTC_C2_CTFG] <= ct_pin;
			// (RULE_15) backup supply sampled each second
			if (sec_tick && bklow_s) ctrl2[`SRTC_C2_VDET] <= 1'b1;
			// (RULE_13) sticky oscillator halt flag
			if (ostop_s) ctrl2[`SRTC_C2_XST] <= 1'b1;
			// (RULE_14) cold start sets the power-on flag
			if (cold_s && !cold_d) begin
				// (RULE_20) clear correction and control, keep halt flag
				adj   <= 8'h00;
				ctrl1 <= 8'h00;
				ctrl2 <= {2'b00, ctrl2[`SRTC_C2_XST] | ostop_s, 5'h10};
			end
		end
	end

	// serial link engine
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			ser_state          <= ST_CMD;
			ser_bit            <= 3'h0;
			ser_sh             <= 8'h00;
			ser_addr           <= 4'h0;
			ser_wr             <= 1'b0;
			ser_wdat           <= 8'h00;
			serial_data_out    <= 1'b0;
			serial_data_oe_out <= 1'b0;
		end else begin
			ser_wr <= 1'b0;
			// (RULE_23) idle while chip select is low
			// (RULE_03) refused while main supply is low
			// (RULE_01) active only with chip select high
			if (!ce_s || vlow_s) begin
				ser_state          <= ST_CMD;
				ser_bit            <= 3'h0;
				serial_data_oe_out <= 1'b0;
			end else if (sclk_rise) begin
				ser_bit <= ser_bit + 3'h1;
				ser_sh  <= {ser_sh[6:0], sdi_s};
				case (ser_state)
					ST_CMD: begin
						if (ser_bit == 3'h7) begin
							ser_addr <= ser_sh[6:3];
							if (ser_sh[`SRTC_CMD_READ - 1]) begin
								// (RULE_22) drive only in the read phase
								ser_state          <= ST_RD;
								ser_sh             <= rd_first;
								serial_data_out    <= rd_first[7];
								serial_data_oe_out <= 1'b1;
							end else begin
								ser_state <= ST_WR;
							end
						end
					end
					ST_WR: begin
						if (ser_bit == 3'h7) begin
							ser_wr   <= 1'b1;
							ser_wdat <= {ser_sh[6:0], sdi_s};
						end
						if (ser_wr) ser_addr <= ser_addr + 4'h1;
					end
					default: begin
						if (ser_bit == 3'h7) begin
							ser_addr        <= ser_addr + 4'h1;
							ser_sh          <= rd_next;
							serial_data_out <= rd_next[7];
						end else begin
							ser_sh          <= {ser_sh[6:0], 1'b0};
							serial_data_out <= ser_sh[6];
						end
					end
				endcase
			end else if (ser_state == ST_WR && ser_wr) begin
				ser_addr <= ser_addr + 4'h1;
			end
		end
	end

	// apb slave, answers one cycle into the access phase, two if a serial write takes that cycle
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
		end else begin
			pready_out  <= apb_acc & ~ser_wr;
			pslverr_out <= apb_acc & ~ser_wr & ~apb_ok;
			prdata_out  <= (apb_acc && !pwrite_in && apb_ok) ? {24'h00_0000, reg_rd(apb_idx)} : 32'h0000_0000;
		end
	end

	// pins: interrupt, supply detect, clock out, threshold select
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			interrupt_out_n          <= 1'b1;
			main_supply_detect_n_out <= 1'b0;
			det_cnt                  <= 22'h0;
			crystal_clock_out        <= 1'b0;
			backup_threshold_sel_out <= 1'b0;
		end else begin
			// (RULE_08) alarms and periodic share the pin
			interrupt_out_n <= ~((ctrl1[`SRTC_C1_WALE] & ctrl2[`SRTC_C2_WAFG]) |
				(ctrl1[`SRTC_C1_DALE] & ctrl2[`SRTC_C2_DAFG]) | ct_pin);
			// (RULE_11) low at once when supply drops
			if (vlow_s) begin
				det_cnt                  <= 22'h0;
				main_supply_detect_n_out <= 1'b0;
			// (RULE_12) release after the detector delay
			end else if (det_cnt >= DET_DELAY_CYCLES - 22'h1) begin
				main_supply_detect_n_out <= 1'b1;
			end else begin
				det_cnt <= det_cnt + 22'h1;
			end
			// (RULE_19) crystal clock always passed out
			crystal_clock_out        <= sync2[4];
			backup_threshold_sel_out <= ctrl2[`SRTC_C2_VDSL];
		end
	end

endmodule

// ==== verification/srtc_core_assertions.sv ====
`timescale 1ns/1ps
module srtc_chk #(
	parameter [21:0] DET_DELAY_CYCLES = 22'h14
) (
	input wire       clock_in,
	input wire       rst_n_in,
	input wire       psel_in,
	input wire       penable_in,
	input wire [7:0] paddr_in,
	input wire       pready_out,
	input wire       pslverr_out,
	input wire       chip_select_in,
	input wire       serial_data_oe_out,
	input wire       crystal_osc_in,
	input wire       crystal_clock_out,
	input wire       main_supply_low_in,
	input wire       main_supply_detect_n_out
);
	reg  [22:0] up_cnt;
	wire        acc;
	// access phase still waiting for its answer
	assign acc = psel_in && penable_in && !pready_out;
	// cycles since the main supply last read low
	always @(posedge clock_in) begin
		if (!rst_n_in || main_supply_low_in)
			up_cnt <= 23'h0;
		else if (!up_cnt[22])
			up_cnt <= up_cnt + 23'h1;
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	a_apb_answer: assert property (acc |-> ##[1:2] pready_out)
		else $error("apb access not answered");
	a_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("pready held too long");
	a_bad_addr: assert property (acc && (paddr_in[1:0] != 2'h0 || paddr_in[7:6] != 2'h0)
		|-> ##[1:2] (pready_out && pslverr_out)) else $error("bad address not refused");
	a_crystal_clock_out_rise: assert property ($rose(crystal_osc_in) |-> ##[2:4] crystal_clock_out)
		else $error("clock output missed a rise");
	a_crystal_clock_out_fall: assert property ($fell(crystal_osc_in) |-> ##[2:4] !crystal_clock_out)
		else $error("clock output missed a fall");
	a_oe_deselect: assert property (!chip_select_in [*6] |-> !serial_data_oe_out)
		else $error("data pin driven while deselected");
	a_oe_supply: assert property (main_supply_low_in [*6] |-> !serial_data_oe_out)
		else $error("data pin driven on low supply");
	a_detect_low: assert property (main_supply_low_in [*6] |-> !main_supply_detect_n_out)
		else $error("detect output not low");
	a_detect_delay: assert property ($rose(main_supply_detect_n_out) |-> up_cnt >= DET_DELAY_CYCLES)
		else $error("detect released too early");
	a_detect_bound: assert property (up_cnt == DET_DELAY_CYCLES + 22'h8 |-> main_supply_detect_n_out)
		else $error("detect released too late");
endmodule

bind srtc_core srtc_chk #(.DET_DELAY_CYCLES(DET_DELAY_CYCLES)) u_chk (
	.clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
	.paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.chip_select_in(chip_select_in), .serial_data_oe_out(serial_data_oe_out),
	.crystal_osc_in(crystal_osc_in), .crystal_clock_out(crystal_clock_out),
	.main_supply_low_in(main_supply_low_in), .main_supply_detect_n_out(main_supply_detect_n_out));

// ==== verification/srtc_host.sv ====
`timescale 1ns/1ps
module srtc_host (
	input  wire clock_in,
	input  wire sio_in,
	output reg  cs_out,
	output reg  sclk_out,
	output reg  sdo_out,
	output reg  soe_out
);
	// idle: deselected, clock still, data line released
	initial begin
		cs_out = 1'b0;
		sclk_out = 1'b0;
		sdo_out = 1'b0;
		soe_out = 1'b0;
	end
	task tick(input integer n);
		repeat (n) @(posedge clock_in);
	endtask
	// command byte then one data byte, msb first; read data sampled on falling edges
	task frame(input [7:0] cmd, input [7:0] wd, output [7:0] rd);
		integer i;
		reg [15:0] bits;
		begin
			bits = {cmd, wd};
			rd = 8'h00;
			// select held over the whole frame
			cs_out <= 1'b1;
			soe_out <= 1'b1;
			tick(8);
			for (i = 0; i < 16; i = i + 1) begin
				sdo_out <= bits[15 - i];
				tick(10);
				// twenty cycles a bit, 1 MHz
				sclk_out <= 1'b1;
				tick(2);
				if (i == 7 && cmd[3])
					soe_out <= 1'b0;
				tick(8);
				sclk_out <= 1'b0;
				if (i >= 7 && i < 15)
					rd = {rd[6:0], sio_in};
			end
			tick(10);
			cs_out <= 1'b0;
			soe_out <= 1'b0;
			tick(1240);
		end
	endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	reg        clk, rst_n, psel, pen, pwr, sup_low, cold, ostop, bklow, xtal, sio_q, e;
	reg  [7:0] paddr, wd, r;
	wire [31:0] prdata;
	wire       pready, pslverr, sdo, soe, int_n, main_supply_detect_n, clko, vsel, hcs, hclk, hdo, hoe, serial_data_io;
	integer    n_fail, n_compared, k;
	time       t0;
	// data line: whoever drives it, else a level that flips every cycle
	assign serial_data_io = soe ? sdo : (hoe ? hdo : ~sio_q);
	srtc_core #(.HALF_SEC_CYCLES(26'h40), .DET_DELAY_CYCLES(22'h14)) dut (
		.clock_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(paddr), .pwdata_in({24'h0, wd}), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .chip_select_in(hcs), .serial_clock_in(hclk), .serial_data_in(serial_data_io),
		.serial_data_out(sdo), .serial_data_oe_out(soe), .crystal_osc_in(xtal),
		.main_supply_low_in(sup_low), .backup_cold_start_in(cold), .osc_stopped_in(ostop),
		.backup_below_in(bklow), .interrupt_out_n(int_n), .main_supply_detect_n_out(main_supply_detect_n),
		.crystal_clock_out(clko), .backup_threshold_sel_out(vsel));
	srtc_host host (.clock_in(clk), .sio_in(serial_data_io), .cs_out(hcs), .sclk_out(hclk), .sdo_out(hdo), .soe_out(hoe));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// released line shows the inverse of the last level, never an unknown
	always @(posedge clk) sio_q <= (serial_data_io === 1'b1);
	// crystal stand-in near 32.768 kHz
	always begin
		repeat (305) @(posedge clk);
		xtal <= ~xtal;
	end
	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("Error at %0t: got %h, expected %h", $time, got, exp);
			end
		end
	endtask
	task tk(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// one apb transfer; only the watchdog ends the wait for pready
	task apb(input w, input [7:0] a, input [7:0] d);
		begin
			psel <= 1'b1;
			pwr <= w;
			paddr <= a;
			wd <= d;
			@(posedge clk);
			pen <= 1'b1;
			@(posedge clk);
			while (pready !== 1'b1)
				@(posedge clk);
			r = prdata[7:0];
			e = pslverr;
			psel <= 1'b0;
			pen <= 1'b0;
			@(posedge clk);
		end
	endtask
	task wr(input [3:0] i, input [7:0] d);
		apb(1'b1, {2'b00, i, 2'b00}, d);
	endtask
	task rd(input [3:0] i, input [7:0] x);
		begin
			apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
			chk(r, x);
		end
	endtask
	// seconds cleared first so no carry lands mid-update
	task st(input [7:0] y, mo, d, h, mi, s);
		begin
			wr(4'h0, 8'h00);
			wr(4'h6, y);
			wr(4'h5, mo);
			wr(4'h4, d);
			wr(4'h2, h);
			wr(4'h1, mi);
			wr(4'h0, s);
		end
	endtask
	task t_regs;
		begin
			rd(4'hF, 8'h30);
			rd(4'h4, 8'h01);
			rd(4'h5, 8'h01);
			wr(4'hD, 8'hFF);
			rd(4'hD, 8'h00);
			apb(1'b0, 8'h40, 8'h00);
			chk({7'h0, e}, 8'h01);
			apb(1'b1, 8'h06, 8'hFF);
			chk({7'h0, e}, 8'h01);
			rd(4'h1, 8'h00);
		end
	endtask
	task t_serial;
		begin
			host.frame(8'h80, 8'h27, r);
			rd(4'h8, 8'h27);
			wr(4'h9, 8'h15);
			host.frame(8'h98, 8'h00, r);
			chk(r, 8'h15);
			chk({7'h0, soe}, 8'h00);
		end
	endtask
	task t_supply;
		begin
			sup_low <= 1'b1;
			tk(6);
			chk({7'h0, main_supply_detect_n}, 8'h00);
			host.frame(8'h80, 8'h5A, r);
			sup_low <= 1'b0;
			t0 = $time;
			rd(4'h8, 8'h27);
			chk({7'h0, main_supply_detect_n}, 8'h00);
			while (main_supply_detect_n !== 1'b1)
				@(posedge clk);
			chk({7'h0, main_supply_detect_n}, 8'h01);
			// bench delay is 20 cycles of 50 ns, plus sync and register lag
			chk({7'h0, ($time - t0) >= 20 * 50}, 8'h01);
			chk({7'h0, ($time - t0) <= 29 * 50}, 8'h01);
		end
	endtask
	task t_leap(input [7:0] y, input [7:0] d, input [7:0] m);
		begin
			st(y, 8'h02, 8'h28, 8'h23, 8'h59, 8'h59);
			tk(200);
			rd(4'h4, d);
			rd(4'h5, m);
		end
	endtask
	task t_alarm(input [7:0] en, input [7:0] mask, input [7:0] fl);
		begin
			wr(4'h8, 8'h30);
			wr(4'h9, 8'h12);
			wr(4'hA, mask);
			wr(4'hB, 8'h30);
			wr(4'hC, 8'h12);
			wr(4'h3, 8'h03);
			wr(4'hE, en);
			wr(4'hF, 8'h00);
			st(8'h24, 8'h06, 8'h12, 8'h12, 8'h29, 8'h59);
			tk(200);
			rd(4'hF, fl);
			chk({7'h0, int_n}, {7'h0, fl == 8'h00});
			wr(4'hF, 8'h00);
			tk(2);
			chk({7'h0, int_n}, 8'h01);
		end
	endtask
	task t_periodic;
		integer c;
		begin
			for (c = 2; c < 8; c = c + 1) begin
				wr(4'hE, 8'h00);
				wr(4'hF, 8'h00);
				st(8'h23, 8'h01, 8'h31, 8'h23, 8'h59, 8'h58);
				wr(4'hE, c[7:0]);
				k = 0;
				while (int_n !== 1'b0 && k < 400) begin
					@(posedge clk);
					k = k + 1;
				end
				chk({7'h0, int_n}, 8'h00);
				k = 0;
				if (c > 3) begin
					tk(150);
					rd(4'hF, 8'h04);
					chk({7'h0, int_n}, 8'h00);
					wr(4'hF, 8'h00);
					tk(2);
				end else begin
					while (int_n !== 1'b1 && k < 200) begin
						@(posedge clk);
						k = k + 1;
					end
				end
				chk({7'h0, int_n}, 8'h01);
			end
		end
	endtask
	// one coarse step stretches one half second every twenty seconds by 1200 cycles
	task t_adj;
		begin
			wr(4'h7, 8'h01);
			wr(4'h0, 8'h00);
			tk(3000);
			apb(1'b0, 8'h00, 8'h00);
			chk({7'h0, r > 8'h12}, 8'h01);
			chk({7'h0, r < 8'h22}, 8'h01);
			wr(4'h7, 8'h00);
		end
	endtask
	task t_flags;
		begin
			wr(4'hE, 8'h00);
			wr(4'hF, 8'h00);
			rd(4'hF, 8'h00);
			ostop <= 1'b1;
			tk(4);
			ostop <= 1'b0;
			tk(4);
			rd(4'hF, 8'h20);
			bklow <= 1'b1;
			tk(260);
			bklow <= 1'b0;
			wr(4'hF, 8'hE0);
			rd(4'hF, 8'hE0);
			chk({7'h0, vsel}, 8'h01);
			wr(4'hE, 8'hC5);
			wr(4'h7, 8'h85);
			cold <= 1'b1;
			tk(6);
			cold <= 1'b0;
			tk(4);
			rd(4'hE, 8'h00);
			rd(4'h7, 8'h00);
			rd(4'hF, 8'h30);
			chk({7'h0, vsel}, 8'h00);
		end
	endtask
	task final_report;
		begin
			$display("Compared %0d, mismatches %0d", n_compared, n_fail);
			if (n_fail == 0 && n_compared > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// watchdog, well past the expected run
	initial begin
		#4000000;
		n_fail = n_fail + 1;
		final_report;
	end
	// main sequence
	initial begin
		n_fail = 0;
		n_compared = 0;
		{rst_n, psel, pen, pwr, sup_low, cold, ostop, bklow, xtal, sio_q} = 10'h000;
		paddr = 8'h00;
		wd = 8'h00;
		tk(6);
		rst_n <= 1'b1;
		t_regs;
		t_serial;
		t_supply;
		t_leap(8'h24, 8'h29, 8'h02);
		t_leap(8'h23, 8'h01, 8'h03);
		t_alarm(8'h80, 8'h08, 8'h02);
		t_alarm(8'h80, 8'h77, 8'h00);
		t_alarm(8'h40, 8'h00, 8'h01);
		t_periodic;
		t_adj;
		t_flags;
		final_report;
	end
endmodule
